// file: core/bmf_pkg.sv
// Constants shared by the bus-matching FIFO pair and its flag logic
package bmf_pkg;
   // ------------------------------------------------------------
   // Data path widths
   // ------------------------------------------------------------
   localparam int DW = 36;            // Long word width
   localparam int WORD_W = 18;        // Word lane width
   localparam int BYTE_W = 9;         // Byte lane width (with parity bit)
   localparam int AW = 8;             // Address bits of each FIFO RAM
   localparam int PW = AW + 1;        // Pointer bits incl. wrap bit
   localparam int DEPTH = 256;        // Long words per FIFO

   // ------------------------------------------------------------
   // Pointer and bus-size codes
   // ------------------------------------------------------------
   localparam logic [PW-1:0] PTR_ONE = 9'h001;   // Pointer step
   localparam logic [PW-1:0] PTR_FULL = 9'h100;  // Occupancy at full
   localparam logic [PW-1:0] PTR_RST = 9'h000;   // Pointer reset value
   localparam logic [1:0] LAST_LONG = 2'h0;      // One part per long word
   localparam logic [1:0] LAST_WORD = 2'h1;      // Two parts per long word
   localparam logic [1:0] LAST_BYTE = 2'h3;      // Four parts per long word
   localparam logic [1:0] IDX_ONE = 2'h1;        // Part index step
   localparam logic [1:0] IDX_RST = 2'h0;        // First part index

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [DW-1:0] DATA_RST = 36'h0_0000_0000;
   localparam logic FLAG_RST = 1'b0;             // Flags low in reset
endpackage : bmf_pkg

// file: core/bmf_core.sv
// Bidirectional FIFO pair with Port B bus matching and port flags
`timescale 1ns/1ps

module bmf_core (
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_endian_and_timing_select_pin,
   input wire logic i_bus_match_select,
   input wire logic i_size_select,
   input wire logic i_porta_wr_en,
   input wire logic [35:0] i_porta_wdata,
   input wire logic i_porta_rd_en,
   input wire logic i_portb_wr_en,
   input wire logic [35:0] i_portb_wdata,
   input wire logic i_portb_rd_en,
   output logic o_porta_input_ready,
   output logic o_porta_output_ready,
   output logic o_porta_empty_flag_n,
   output logic [35:0] o_porta_rdata,
   output logic o_portb_input_ready,
   output logic o_portb_output_ready,
   output logic o_portb_empty_flag_n,
   output logic [35:0] o_portb_rdata
);
   // ------------------------------------------------------------
   // Local aliases of shared constants
   // ------------------------------------------------------------
   localparam int DW = bmf_pkg::DW;
   localparam int AW = bmf_pkg::AW;
   localparam int PW = bmf_pkg::PW;
   localparam int WW = bmf_pkg::WORD_W;
   localparam int BW = bmf_pkg::BYTE_W;
   localparam logic [PW-1:0] P1 = bmf_pkg::PTR_ONE;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Last part index for the selected Port B width
   function automatic logic [1:0] f_last(input logic bm, input logic sz);
      return bm ? (sz ? bmf_pkg::LAST_BYTE : bmf_pkg::LAST_WORD)
                : bmf_pkg::LAST_LONG;
   endfunction : f_last

   // Lane slot of a part; big endian starts at the top
   function automatic logic [1:0] f_slot(input logic [1:0] idx,
         input logic [1:0] last, input logic be);
      return be ? 2'(last - idx) : idx;
   endfunction : f_slot

   // Pick one part of a long word onto the low lanes
   function automatic logic [DW-1:0] f_get(input logic [DW-1:0] lw,
         input logic [1:0] slot, input logic [1:0] last);
      logic [DW-1:0] r;
      r = lw;
      case (last)
         // Upper lanes are don't-care; zero keeps them tidy
         bmf_pkg::LAST_WORD: r = {{(DW-WW){1'b0}}, lw[WW*slot +: WW]};
         bmf_pkg::LAST_BYTE: r = {{(DW-BW){1'b0}}, lw[BW*slot +: BW]};
         default: r = lw;
      endcase
      return r;
   endfunction : f_get

   // Drop one narrow part into its lane of the assembly word
   function automatic logic [DW-1:0] f_put(input logic [DW-1:0] acc,
         input logic [DW-1:0] din, input logic [1:0] slot,
         input logic [1:0] last);
      logic [DW-1:0] r;
      r = acc;
      case (last)
         bmf_pkg::LAST_WORD: r[WW*slot +: WW] = din[WW-1:0];
         bmf_pkg::LAST_BYTE: r[BW*slot +: BW] = din[BW-1:0];
         default: r = din;
      endcase
      return r;
   endfunction : f_put

   // ------------------------------------------------------------
   // Configuration straps
   // ------------------------------------------------------------
   logic be_q;        // Big endian byte order
   logic first_word_fall_through_mode_q;      // First word fall through timing
   logic cfg_q;       // Timing mode already sampled
   logic [1:0] last_idx;

   // Endian taken while reset is held, timing mode just after release
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         be_q <= i_endian_and_timing_select_pin;
         first_word_fall_through_mode_q <= 1'b0;
         cfg_q <= 1'b0;
      end else if (!cfg_q) begin
         first_word_fall_through_mode_q <= i_endian_and_timing_select_pin;
         cfg_q <= 1'b1;
      end
   end

   // Width selects are static, so decode is plain logic
   assign last_idx = f_last(i_bus_match_select, i_size_select);

   // ------------------------------------------------------------
   // FIFO1: Port A writes, Port B reads with bus matching
   // ------------------------------------------------------------
   logic [DW-1:0] mem1 [0:bmf_pkg::DEPTH-1];
   logic [PW-1:0] w1_q, r1_q;     // Write and read pointers
   logic [PW-1:0] w1_s_q, r1_s_q; // Pointers retimed to far port
   logic [PW-1:0] w1_d, r1_d;
   logic [DW-1:0] hold1_q;        // Auxiliary long word store
   logic hv1_q;                   // Hold register in use
   logic [1:0] idx1_q;            // Next part to deliver
   logic [DW-1:0] word1;
   logic wr1, ne1, adv1, last1, flagb_d;

   assign wr1 = i_porta_wr_en && o_porta_input_ready;
   assign ne1 = w1_s_q != r1_q;
   assign last1 = idx1_q == last_idx;
   // Parts after the first come from the hold register
   assign word1 = hv1_q ? hold1_q : mem1[r1_q[AW-1:0]];
   // Step the output register: on read, or ahead of it in FIRST_WORD_FALL_THROUGH_MODE
   assign adv1 = first_word_fall_through_mode_q ? (ne1 && (!o_portb_output_ready || i_portb_rd_en))
                        : (i_portb_rd_en && o_portb_empty_flag_n);
   assign w1_d = wr1 ? w1_q + P1 : w1_q;
   // Slot is released only with the final part
   assign r1_d = (adv1 && last1) ? r1_q + P1 : r1_q;
   // Flag stays up while parts of a long word remain
   assign flagb_d = first_word_fall_through_mode_q ? (adv1 || (o_portb_output_ready &&
                             !i_portb_rd_en)) : (w1_s_q != r1_d);

   // RAM write, no reset needed for storage
   always_ff @(posedge i_sys_clk) begin
      if (wr1) begin
         mem1[w1_q[AW-1:0]] <= i_porta_wdata;
      end
   end

   // Pointers and their one-stage retiming to the other port
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         w1_q <= bmf_pkg::PTR_RST;
         r1_q <= bmf_pkg::PTR_RST;
         w1_s_q <= bmf_pkg::PTR_RST;
         r1_s_q <= bmf_pkg::PTR_RST;
      end else begin
         w1_q <= w1_d;
         r1_q <= r1_d;
         w1_s_q <= w1_q;
         r1_s_q <= r1_q;
      end
   end

   // Part sequencing onto the Port B output register
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_portb_rdata <= bmf_pkg::DATA_RST;
         hold1_q <= bmf_pkg::DATA_RST;
         hv1_q <= 1'b0;
         idx1_q <= bmf_pkg::IDX_RST;
      end else if (adv1) begin
         // Order and lanes per width and endian
         o_portb_rdata <= f_get(word1, f_slot(idx1_q, last_idx, be_q),
                                last_idx);
         if (last1) begin
            hv1_q <= 1'b0;
            idx1_q <= bmf_pkg::IDX_RST;
         end else begin
            hold1_q <= word1;
            hv1_q <= 1'b1;
            idx1_q <= idx1_q + bmf_pkg::IDX_ONE;
         end
      end
   end

   // Port B read flags and Port A input ready
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_portb_output_ready <= bmf_pkg::FLAG_RST;
         o_portb_empty_flag_n <= bmf_pkg::FLAG_RST;
         o_porta_input_ready <= bmf_pkg::FLAG_RST;
      end else begin
         o_portb_output_ready <= first_word_fall_through_mode_q && flagb_d;
         o_portb_empty_flag_n <= !first_word_fall_through_mode_q && flagb_d;
         // Free space judged on Port A from retimed read pointer
         o_porta_input_ready <= (w1_d - r1_s_q) != bmf_pkg::PTR_FULL;
      end
   end

   // ------------------------------------------------------------
   // FIFO2: Port B writes with bus matching, Port A reads
   // ------------------------------------------------------------
   logic [DW-1:0] mem2 [0:bmf_pkg::DEPTH-1];
   logic [PW-1:0] w2_q, r2_q, w2_s_q, r2_s_q, w2_d, r2_d;
   logic [DW-1:0] acc2_q;         // Assembly of narrow writes
   logic [1:0] idx2_q;            // Next part to accept
   logic [DW-1:0] full2;
   logic wr2, last2, ne2, adv2, flaga_d;

   assign wr2 = i_portb_wr_en && o_portb_input_ready;
   assign last2 = idx2_q == last_idx;
   assign full2 = f_put(acc2_q, i_portb_wdata,
                        f_slot(idx2_q, last_idx, be_q), last_idx);
   assign ne2 = w2_s_q != r2_q;
   assign adv2 = first_word_fall_through_mode_q ? (ne2 && (!o_porta_output_ready || i_porta_rd_en))
                        : (i_porta_rd_en && o_porta_empty_flag_n);
   // Pointer moves only when a whole long word lands
   assign w2_d = (wr2 && last2) ? w2_q + P1 : w2_q;
   assign r2_d = adv2 ? r2_q + P1 : r2_q;
   assign flaga_d = first_word_fall_through_mode_q ? (adv2 || (o_porta_output_ready &&
                             !i_porta_rd_en)) : (w2_s_q != r2_d);

   // RAM commit on the final part of a long word
   always_ff @(posedge i_sys_clk) begin
      if (wr2 && last2) begin
         mem2[w2_q[AW-1:0]] <= full2;
      end
   end

   // Auxiliary registers collect earlier parts
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         acc2_q <= bmf_pkg::DATA_RST;
         idx2_q <= bmf_pkg::IDX_RST;
      end else if (wr2) begin
         acc2_q <= full2;
         idx2_q <= last2 ? bmf_pkg::IDX_RST : idx2_q + bmf_pkg::IDX_ONE;
      end
   end

   // Pointers and retiming
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         w2_q <= bmf_pkg::PTR_RST;
         r2_q <= bmf_pkg::PTR_RST;
         w2_s_q <= bmf_pkg::PTR_RST;
         r2_s_q <= bmf_pkg::PTR_RST;
      end else begin
         w2_q <= w2_d;
         r2_q <= r2_d;
         w2_s_q <= w2_q;
         r2_s_q <= r2_q;
      end
   end

   // Port A output register and flags
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         o_porta_rdata <= bmf_pkg::DATA_RST;
         o_porta_output_ready <= bmf_pkg::FLAG_RST;
         o_porta_empty_flag_n <= bmf_pkg::FLAG_RST;
         o_portb_input_ready <= bmf_pkg::FLAG_RST;
      end else begin
         if (adv2) begin
            o_porta_rdata <= mem2[r2_q[AW-1:0]];
         end
         o_porta_output_ready <= first_word_fall_through_mode_q && flaga_d;
         o_porta_empty_flag_n <= !first_word_fall_through_mode_q && flaga_d;
         o_portb_input_ready <= (w2_d - r2_s_q) != bmf_pkg::PTR_FULL;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_first_part;
      adv1 && idx1_q == bmf_pkg::IDX_RST;
   endsequence

   a_word_order: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      s_first_part and last_idx == bmf_pkg::LAST_WORD |=>
      o_portb_rdata[WW-1:0] == (be_q ? $past(word1[DW-1 -: WW])
                                     : $past(word1[WW-1:0])))
      else $error("word part order wrong");

   a_byte_order: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      s_first_part and last_idx == bmf_pkg::LAST_BYTE |=>
      o_portb_rdata[BW-1:0] == (be_q ? $past(word1[DW-1 -: BW])
                                     : $past(word1[BW-1:0])))
      else $error("byte part order wrong");

   a_endian_held: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      $past(i_nrst) |-> $stable(be_q))
      else $error("endian changed outside reset");

   a_ready_fall: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      first_word_fall_through_mode_q && cfg_q && wr1 && w1_q == r1_q && !hv1_q
      |-> ##[1:3] o_portb_output_ready)
      else $error("port B ready late");

   a_ready_hold: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      first_word_fall_through_mode_q && o_portb_output_ready && i_portb_rd_en && hv1_q
      |=> o_portb_output_ready)
      else $error("port B ready dropped early");

   a_empty_rise: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      !first_word_fall_through_mode_q && cfg_q && wr1 ##1 !adv1 ##1 !adv1 |=> o_portb_empty_flag_n)
      else $error("port B empty flag late");

   a_empty_hold: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      !first_word_fall_through_mode_q && adv1 && !last1 |=> o_portb_empty_flag_n)
      else $error("port B empty on partial read");

   a_space_free: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      (adv1 && last1 && !wr1) ##1 !wr1 ##1 !wr1
      |=> o_porta_input_ready)
      else $error("port A input ready late");

   a_commit_last: assert property (@(posedge i_sys_clk)
      disable iff (!i_nrst)
      wr2 && !last2 |=> $stable(w2_q))
      else $error("partial write reached memory");
endmodule : bmf_core

// file: dv/bmf_src.sv
// Port A producer model writing long words into the block
`timescale 1ns/1ps
module bmf_src (
   input wire logic i_sys_clk,
   output logic o_wr_en,
   output logic [35:0] o_wdata
);
   // ------------------------------------------------------------
   // Port A write strobe and data
   // ------------------------------------------------------------
   initial begin
      o_wr_en = 1'b0;
      o_wdata = 36'h0_0000_0000;
   end

   // One strobe carries one whole long word on A35..A0
   // Strobe held through a burst so it never toggles in one step
   task automatic put(input logic [35:0] d, input logic more);
      o_wr_en <= 1'b1;
      o_wdata <= d;
      @(posedge i_sys_clk);
      if (!more) begin
         o_wr_en <= 1'b0;
         o_wdata <= ~d; // Idle lanes never echo the last word
      end
   endtask : put
endmodule : bmf_src

// file: dv/testbench.sv
// Self-checking bench for the bus-matching FIFO pair and its flags
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   fails++; $display("ERROR %s exp %h got %h", n, e, a); end end
module testbench;
   // ------------------------------------------------------------
   // Stimulus, config record and scoreboard
   // ------------------------------------------------------------
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic pin = 1'b0;
   logic bm = 1'b0;
   logic sz = 1'b0;
   logic rd_a = 1'b0;
   logic rd_b = 1'b0;
   logic wr_b = 1'b0;
   logic [35:0] wd_b = 36'h0_0000_0000;
   logic wr_a, ir_a, or_a, ef_a, ir_b, or_b, ef_b;
   logic [35:0] wd_a, rdat_a, rdat_b, ev;
   logic be = 1'b0; // Endian the design should hold
   logic ff = 1'b0; // Timing mode the design should hold
   logic acc_a_q, acc_b_q;
   logic [1:0] pidx_q; // Part index within the long word
   logic [2:0] np; // Parts per long word
   logic [35:0] msk; // Valid Port B lanes; others undefined
   logic [35:0] qa[$];
   logic [35:0] qb[$];
   logic [31:0] seed = 32'h0000_58E5;
   int fails = 0;
   int tests_run = 0;
   wire logic fl_b = ff ? or_b : ef_b;
   wire logic fl_a = ff ? or_a : ef_a;
   assign np = !bm ? 3'h1 : (sz ? 3'h4 : 3'h2);
   assign msk = !bm ? 36'hF_FFFF_FFFF :
      (sz ? 36'h0_0000_01FF : 36'h0_0003_FFFF);

   always #10 clk = ~clk;

   bmf_core dut (.i_sys_clk(clk), .i_nrst(nrst),
      .i_endian_and_timing_select_pin(pin), .i_bus_match_select(bm),
      .i_size_select(sz), .i_porta_wr_en(wr_a), .i_porta_wdata(wd_a),
      .i_porta_rd_en(rd_a), .i_portb_wr_en(wr_b), .i_portb_wdata(wd_b),
      .i_portb_rd_en(rd_b), .o_porta_input_ready(ir_a),
      .o_porta_output_ready(or_a), .o_porta_empty_flag_n(ef_a),
      .o_porta_rdata(rdat_a), .o_portb_input_ready(ir_b),
      .o_portb_output_ready(or_b), .o_portb_empty_flag_n(ef_b),
      .o_portb_rdata(rdat_b));
   bmf_src src (.i_sys_clk(clk), .o_wr_en(wr_a), .o_wdata(wd_a));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic [35:0] rw();
      logic [31:0] h;
      h = rnd();
      return {h[3:0], rnd()};
   endfunction : rw
   // Part i of a long word in delivery order, in the low lanes
   function automatic logic [35:0] part(logic [35:0] w, int i);
      int s;
      s = be ? int'(np) - 1 - i : i;
      return (w >> (s * (36 / int'(np)))) & msk;
   endfunction : part

   // Results watcher: oldest expectation against each delivery
   always @(posedge clk) begin
      if (!nrst) begin
         acc_a_q <= 1'b0;
         acc_b_q <= 1'b0;
         pidx_q <= 2'h0;
      end else begin
         if (ff ? (rd_b & or_b) : acc_b_q) begin
            ev = qb.pop_front();
            `CHK("portb_rdata", ev, rdat_b & msk)
         end
         if (ff ? (rd_a & or_a) : acc_a_q) begin
            ev = qa.pop_front();
            `CHK("porta_rdata", ev, rdat_a)
         end
         if (acc_b_q && pidx_q != 2'h0)
            `CHK("portb_flag_mid", 1'b1, fl_b)
         acc_b_q <= rd_b & fl_b;
         acc_a_q <= rd_a & fl_a;
         if (rd_b & fl_b)
            pidx_q <= ({1'b0, pidx_q} == np - 3'h1) ? 2'h0 : pidx_q + 2'h1;
      end
   end

   // Mode and endian set in reset; pin then means timing, then noise
   task automatic rst(input logic [1:0] m, input logic e, input logic f);
      @(posedge clk);
      nrst <= 1'b0;
      pin <= e;
      bm <= m != 2'h0; // Size pins move only inside reset
      sz <= m == 2'h2;
      be <= e; // Watcher still judges this edge in the old mode
      ff <= f;
      repeat (10) @(posedge clk);
      qa.delete();
      qb.delete();
      nrst <= 1'b1;
      pin <= f;
      @(posedge clk);
      pin <= ~e; // Endian must not follow the pin
      @(posedge clk);
   endtask : rst
   // Flag k is low after the current edge and high n edges on
   task automatic lat(input int k, input int n);
      logic f;
      for (int i = 0; i <= n; i++) begin
         #1;
         f = k == 0 ? fl_b : (k == 1 ? fl_a : ir_a);
         `CHK("flag_latency", i == n, f)
         if (i < n) @(posedge clk);
      end
   endtask : lat
   // Read strobe held until n parts are taken; refused ones repeat
   task automatic rdn(input int n, input logic a);
      int k;
      int t;
      k = 0;
      t = 0;
      @(posedge clk);
      if (a) rd_a <= 1'b1;
      else rd_b <= 1'b1;
      while (k < n && t < 3000) begin
         @(posedge clk);
         t++;
         if (a ? (rd_a & fl_a) : (rd_b & fl_b)) k++;
      end
      rd_a <= 1'b0;
      rd_b <= 1'b0;
      if (k < n) fails++;
   endtask : rdn
   task automatic put_a(input logic more);
      logic [35:0] w;
      w = rw();
      for (int i = 0; i < np; i++) qb.push_back(part(w, i));
      src.put(w, more);
   endtask : put_a
   // Narrow writes with junk in the unused upper lanes
   task automatic put_b(input logic [35:0] w);
      for (int i = 0; i < np; i++) begin
         @(posedge clk);
         wr_b <= 1'b1;
         wd_b <= part(w, i) | ({rnd(), 4'h0} & ~msk);
      end
      @(posedge clk);
      wr_b <= 1'b0;
      qa.push_back(w);
   endtask : put_b
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // Main sequence: every width, endian and timing mode
   // ------------------------------------------------------------
   initial begin
      for (int c = 0; c < 12; c++) begin
         rst(2'(c / 4), c[1], c[0]);
         put_a(1'b0);
         lat(0, 2);
         `CHK("portb_flag_unused", 1'b0, ff ? ef_b : or_b)
         rdn(int'(np), 1'b0);
         #1;
         `CHK("portb_flag_end", 1'b0, fl_b)
         @(posedge clk); // Next writes start on an edge
         repeat (2) put_a(1'b1);
         put_a(1'b0);
         rdn(3 * int'(np), 1'b0);
         put_b(rw());
         lat(1, 2);
         `CHK("portb_input_ready", 1'b1, ir_b)
         rdn(1, 1'b1);
      end
      // Fill FIFO1, one refused write, free by the final byte
      rst(2'h2, 1'b0, 1'b0);
      repeat (256) put_a(1'b1);
      src.put(rw(), 1'b0);
      @(posedge clk);
      #1;
      `CHK("porta_input_ready_full", 1'b0, ir_a)
      rdn(3, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      `CHK("porta_input_ready_part", 1'b0, ir_a)
      rdn(1, 1'b0);
      lat(2, 2);
      rdn(1020, 1'b0);
      repeat (3) @(posedge clk);
      #1;
      `CHK("portb_flag_drained", 1'b0, fl_b)
      finish_test;
   end

   // Watchdog well beyond the few thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test;
   end
endmodule : testbench
